// ===== core/imdu_defs.vh
// constants shared by the iterative multiply/divide unit
`ifndef IMDU_DEFS_VH
`define IMDU_DEFS_VH

// ----------------------------------------------------------------
// control register layout
// ----------------------------------------------------------------
`define IMDU_CTRL_W        8
`define IMDU_RUN_BIT       7
`define IMDU_MODE_BIT      0
`define IMDU_CTRL_RESET    8'h00
`define IMDU_MODE_MUL      1'b1
`define IMDU_MODE_DIV      1'b0

// ----------------------------------------------------------------
// data register widths and reset values
// ----------------------------------------------------------------
`define IMDU_HALF_W        16
`define IMDU_HALF_RESET    16'h0000

// ----------------------------------------------------------------
// iteration counts, one bit per clock
// ----------------------------------------------------------------
`define IMDU_MUL_STEPS     16
`define IMDU_DIV_STEPS     32
`define IMDU_CNT_W         6

`endif

// ===== core/imdu_step.v
// one iteration of the shift-and-add multiplier and restoring divider
`include "imdu_defs.vh"

module imdu_step #(
	parameter W = `IMDU_HALF_W
) (
	input  wire         mode_mul,
	input  wire [W-1:0] acc_high_in,
	input  wire [W-1:0] acc_low_in,
	input  wire [W-1:0] rem_in,
	input  wire [W-1:0] operand,
	output reg  [W-1:0] acc_high_out,
	output reg  [W-1:0] acc_low_out,
	output reg  [W-1:0] rem_out
);

	// ----------------------------------------------------------------
	// datapath
	// ----------------------------------------------------------------
	reg [W:0]   sum;
	reg [W:0]   trial;
	reg [W+1:0] diff;
	reg         fits;

	always @* begin
		sum          = {1'b0, acc_high_in} + (acc_low_in[0] ? {1'b0, operand} : {(W+1){1'b0}});
		trial        = {rem_in, acc_high_in[W-1]};
		diff         = {1'b0, trial} - {2'b00, operand};
		fits         = ~diff[W+1];
		acc_high_out = acc_high_in;
		acc_low_out  = acc_low_in;
		rem_out      = rem_in;
		if (mode_mul) begin
			// add when the low multiplier bit is one, then shift the pair right
			acc_high_out = sum[W:1];
			acc_low_out  = {sum[0], acc_low_in[W-1:1]};
			rem_out      = {W{1'b0}};
		end else begin
			// restoring subtract; quotient bit enters at the bottom
			acc_high_out = {acc_high_in[W-2:0], acc_low_in[W-1]};
			acc_low_out  = {acc_low_in[W-2:0], fits};
			rem_out      = fits ? diff[W-1:0] : trial[W-1:0];
		end
	end

endmodule

// ===== core/imdu_top.v
// iterative 16x16 multiplier and 32/16 divider with control and result registers
//
// Summary of operation
// - writing control with mode bit 0 and run bit 7 set starts a multiplication
// - multiplication finishes sixteen clocks after the start
// - accumulator halves hold intermediate values while multiplying; reads then are meaningless
// - finished multiplication leaves the 32-bit product across both accumulator halves
// - run bit clears itself when either operation finishes
// - every finished operation pulses the done interrupt request
// - writing control with mode bit clear and run bit set starts a division
// - division finishes thirty-two clocks after the start
// - accumulator and remainder hold intermediate values while dividing
// - finished division leaves quotient in accumulator and remainder in remainder register
// - starting a multiplication clears accumulator high; remainder stays zero in that mode
// - remainder clears whenever an operation starts
// - clearing run bit mid-operation stops it; result then undefined, restart needed
`include "imdu_defs.vh"

module imdu_top #(
	parameter W         = `IMDU_HALF_W,
	parameter MUL_STEPS = `IMDU_MUL_STEPS,
	parameter DIV_STEPS = `IMDU_DIV_STEPS
) (
	input  wire                     clock,
	input  wire                     reset_n,
	input  wire                     acc_low_we,
	input  wire                     acc_high_we,
	input  wire                     operand_we,
	input  wire                     ctrl_we,
	input  wire [W-1:0]             wr_data,
	input  wire [`IMDU_CTRL_W-1:0]  ctrl_wr_data,
	output reg  [W-1:0]             accumulator_low,
	output reg  [W-1:0]             accumulator_high,
	output reg  [W-1:0]             operand_reg,
	output reg  [W-1:0]             remainder_reg,
	output reg  [`IMDU_CTRL_W-1:0]  arith_control_reg,
	output reg                      arith_done_irq
);

	// ----------------------------------------------------------------
	// reset release
	// ----------------------------------------------------------------
	// internal reset lifts on the second rising edge after release
	reg rst_meta_q;
	reg rst_sync_q;

	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end

	wire rst_n = rst_sync_q;

	// ----------------------------------------------------------------
	// state machine
	// ----------------------------------------------------------------
	localparam [1:0] ST_IDLE = 2'b01;
	localparam [1:0] ST_BUSY = 2'b10;

	localparam integer MUL_LAST_I = MUL_STEPS - 1;
	localparam integer DIV_LAST_I = DIV_STEPS - 1;

	localparam [`IMDU_CNT_W-1:0] MUL_LAST = MUL_LAST_I[`IMDU_CNT_W-1:0];
	localparam [`IMDU_CNT_W-1:0] DIV_LAST = DIV_LAST_I[`IMDU_CNT_W-1:0];
	localparam [`IMDU_CNT_W-1:0] CNT_ONE  = 6'h01;

	reg [1:0]             state_q;
	reg [1:0]             state_d;
	reg [`IMDU_CNT_W-1:0] count_q;
	reg [`IMDU_CNT_W-1:0] count_d;

	// ----------------------------------------------------------------
	// mode decode
	// ----------------------------------------------------------------
	function is_mul(input mode);
		is_mul = (mode == `IMDU_MODE_MUL);
	endfunction

	wire arith_mode_select = arith_control_reg[`IMDU_MODE_BIT];
	wire wr_run            = ctrl_wr_data[`IMDU_RUN_BIT];
	wire wr_mode           = ctrl_wr_data[`IMDU_MODE_BIT];

	wire start     = ctrl_we & wr_run;
	wire stop_req  = ctrl_we & ~wr_run;
	wire busy      = state_q[1];
	wire last_step = busy & (count_q == (is_mul(arith_mode_select) ? MUL_LAST : DIV_LAST));

	// ----------------------------------------------------------------
	// one arithmetic step
	// ----------------------------------------------------------------
	wire [W-1:0] step_high;
	wire [W-1:0] step_low;
	wire [W-1:0] step_rem;

	// operand and mode must hold while busy, the step reads them every clock
	imdu_step #(
		.W            (W)
	) u_step (
		.mode_mul     (arith_mode_select),
		.acc_high_in  (accumulator_high),
		.acc_low_in   (accumulator_low),
		.rem_in       (remainder_reg),
		.operand      (operand_reg),
		.acc_high_out (step_high),
		.acc_low_out  (step_low),
		.rem_out      (step_rem)
	);

	// ----------------------------------------------------------------
	// sequencing
	// ----------------------------------------------------------------
	always @* begin
		state_d = state_q;
		count_d = count_q;
		case (state_q)
			ST_IDLE: begin
				if (start) begin
					state_d = ST_BUSY;
					count_d = {`IMDU_CNT_W{1'b0}};
				end
			end
			ST_BUSY: begin
				if (last_step) begin
					// finishing beats a clear in the same cycle
					state_d = ST_IDLE;
				end else if (start) begin
					// a fresh start while busy restarts the count
					state_d = ST_BUSY;
					count_d = {`IMDU_CNT_W{1'b0}};
				end else if (stop_req) begin
					state_d = ST_IDLE;
				end else begin
					count_d = count_q + CNT_ONE;
				end
			end
			default: begin
				state_d = ST_IDLE;
				count_d = {`IMDU_CNT_W{1'b0}};
			end
		endcase
	end

	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ST_IDLE;
			count_q <= {`IMDU_CNT_W{1'b0}};
		end else begin
			state_q <= state_d;
			count_q <= count_d;
		end
	end

	// ----------------------------------------------------------------
	// control register and done request
	// ----------------------------------------------------------------
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			arith_control_reg <= `IMDU_CTRL_RESET;
			arith_done_irq    <= 1'b0;
		end else begin
			arith_done_irq <= last_step;
			// any control write in the finishing cycle is dropped
			if (last_step) begin
				arith_control_reg[`IMDU_RUN_BIT] <= 1'b0;
			end else if (ctrl_we) begin
				arith_control_reg <= {wr_run, {(`IMDU_CTRL_W-2){1'b0}}, wr_mode};
			end
		end
	end

	// ----------------------------------------------------------------
	// data registers
	// ----------------------------------------------------------------
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			operand_reg <= `IMDU_HALF_RESET;
		end else if (operand_we) begin
			operand_reg <= wr_data;
		end
	end

	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			accumulator_low  <= `IMDU_HALF_RESET;
			accumulator_high <= `IMDU_HALF_RESET;
			remainder_reg    <= `IMDU_HALF_RESET;
		end else if (start && !last_step) begin
			// accumulator high keeps a same-cycle write only for division
			remainder_reg <= `IMDU_HALF_RESET;
			if (is_mul(wr_mode)) begin
				accumulator_high <= `IMDU_HALF_RESET;
			end
			if (acc_low_we) begin
				accumulator_low <= wr_data;
			end
			if (acc_high_we && !is_mul(wr_mode)) begin
				accumulator_high <= wr_data;
			end
		end else if (busy) begin
			// intermediate values live in the result registers
			accumulator_low  <= acc_low_we ? wr_data : step_low;
			accumulator_high <= acc_high_we ? wr_data : step_high;
			remainder_reg    <= step_rem;
		end else begin
			if (acc_low_we) begin
				accumulator_low <= wr_data;
			end
			if (acc_high_we) begin
				accumulator_high <= wr_data;
			end
		end
	end

endmodule

// ===== test/imdu_monitor.sv
// timing checker for the multiply/divide unit
module imdu_monitor #(
	parameter W         = 16,
	parameter MUL_STEPS = 16,
	parameter DIV_STEPS = 32
) (
	input wire logic         clock,
	input wire logic         reset_n,
	input wire logic         ctrl_we,
	input wire logic [7:0]   ctrl_wr_data,
	input wire logic [W-1:0] accumulator_high,
	input wire logic [W-1:0] remainder_reg,
	input wire logic [7:0]   arith_control_reg,
	input wire logic         arith_done_irq
);
	timeunit 1ns;
	timeprecision 1ps;
	logic       act_q;
	logic       mul_q;
	logic [5:0] cyc_q;
	logic       fin_c;
	int         steps;
	assign steps = mul_q ? MUL_STEPS : DIV_STEPS;
	// a control write in the finishing cycle is overridden by completion
	assign fin_c = act_q && int'(cyc_q) == steps - 1;
	// cycles since the last accepted start
	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			act_q <= 1'b0;
			mul_q <= 1'b0;
			cyc_q <= 6'h00;
		end else if (ctrl_we && !fin_c) begin
			act_q <= ctrl_wr_data[7];
			mul_q <= ctrl_wr_data[0];
			cyc_q <= 6'h00;
		end else if (act_q && int'(cyc_q) == steps) begin
			act_q <= 1'b0;
		end else if (act_q) begin
			cyc_q <= cyc_q + 6'h01;
		end
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);
	sequence s_start; ctrl_we && ctrl_wr_data[7] && !fin_c; endsequence
	sequence s_busy; act_q && int'(cyc_q) < steps; endsequence
	sequence s_end; act_q && int'(cyc_q) == steps; endsequence
	sequence s_stop; ctrl_we && !ctrl_wr_data[7] && !fin_c; endsequence
	a_start_ctrl: assert property (s_start |=> arith_control_reg == {1'b1, 6'h00, $past(ctrl_wr_data[0])})
		else $error("control wrong after start");
	a_start_rem: assert property (s_start |=> remainder_reg == {W{1'b0}})
		else $error("remainder not cleared at start");
	a_mul_high: assert property (ctrl_we && ctrl_wr_data == 8'h81 && !fin_c |=> accumulator_high == {W{1'b0}})
		else $error("high half not cleared");
	a_mul_rem: assert property (act_q && mul_q |-> remainder_reg == {W{1'b0}})
		else $error("remainder nonzero while multiplying");
	a_run_held: assert property (s_busy |-> arith_control_reg[7] && !arith_done_irq)
		else $error("operation ended early");
	a_op_done: assert property (s_end |-> arith_done_irq && !arith_control_reg[7])
		else $error("operation did not end on time");
	a_irq_cause: assert property (arith_done_irq |-> s_end)
		else $error("done request without completion");
	a_irq_pulse: assert property (arith_done_irq |=> !arith_done_irq)
		else $error("done request longer than one cycle");
	a_stop_halt: assert property (s_stop |=> !arith_control_reg[7])
		else $error("run bit kept after stop");
endmodule

bind imdu_top imdu_monitor #(.W(W), .MUL_STEPS(MUL_STEPS), .DIV_STEPS(DIV_STEPS)) i_imdu_monitor (
	.clock(clock), .reset_n(reset_n), .ctrl_we(ctrl_we), .ctrl_wr_data(ctrl_wr_data),
	.accumulator_high(accumulator_high), .remainder_reg(remainder_reg),
	.arith_control_reg(arith_control_reg), .arith_done_irq(arith_done_irq));

// ===== test/iterative_mul_div_unit_tb.sv
// self-checking bench for the multiply/divide unit
module iterative_mul_div_unit_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clock, reset_n, irq;
	logic        acc_low_we, acc_high_we, operand_we, ctrl_we;
	logic [15:0] wr_data, acc_lo, acc_hi, opnd, rem;
	logic [7:0]  ctrl_wr_data, ctrl;
	int          err_count, tests_run;
	imdu_top i_imdu_top (.clock(clock), .reset_n(reset_n), .acc_low_we(acc_low_we),
		.acc_high_we(acc_high_we), .operand_we(operand_we), .ctrl_we(ctrl_we), .wr_data(wr_data),
		.ctrl_wr_data(ctrl_wr_data), .accumulator_low(acc_lo), .accumulator_high(acc_hi),
		.operand_reg(opnd), .remainder_reg(rem), .arith_control_reg(ctrl), .arith_done_irq(irq));
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	task final_report;
		if (err_count == 0 && tests_run > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task cmp(input string s, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			err_count++;
			$display("Error %s expected %h seen %h", s, e, g);
		end
	endtask
	// k is one-hot {low, high, operand}
	task wr(input logic [2:0] k, input logic [15:0] d);
		@(negedge clock);
		wr_data = d;
		{acc_low_we, acc_high_we, operand_we} = k;
		@(negedge clock);
		{acc_low_we, acc_high_we, operand_we} = 3'h0;
	endtask
	task wc(input logic [7:0] c);
		@(negedge clock);
		ctrl_wr_data = c;
		ctrl_we = 1'b1;
		@(negedge clock);
		ctrl_we = 1'b0;
	endtask
	task run(input logic [7:0] c, output int n);
		wc(c);
		for (n = 0; n < 40 && irq !== 1'b1; n++) @(negedge clock);
	endtask
	task t_reset;
		cmp("reset acc", 32'h0000_0000, {acc_hi, acc_lo});
		cmp("reset misc", 32'h0000_0000, {rem, ctrl, 7'h00, irq});
	endtask
	task t_mul(input logic [15:0] a, input logic [15:0] b);
		int n;
		wr(3'h2, 16'hffff);
		wr(3'h4, a);
		wr(3'h1, b);
		cmp("operand", {16'h0000, b}, {16'h0000, opnd});
		run(8'h81, n);
		cmp("mul cycles", 16, n);
		cmp("product", 32'(a) * 32'(b), {acc_hi, acc_lo});
		cmp("mul remainder", 32'h0000_0000, {16'h0000, rem});
		cmp("mul control", 32'h0000_0001, {24'h00_0000, ctrl});
		cmp("mul irq", 32'h0000_0001, {31'h0000_0000, irq});
	endtask
	task t_div(input logic [31:0] a, input logic [15:0] b);
		int n;
		wr(3'h2, a[31:16]);
		wr(3'h4, a[15:0]);
		wr(3'h1, b);
		run(8'h80, n);
		cmp("div cycles", 32, n);
		cmp("quotient", a / 32'(b), {acc_hi, acc_lo});
		cmp("remainder", a % 32'(b), {16'h0000, rem});
		cmp("div control", 32'h0000_0000, {24'h00_0000, ctrl});
		cmp("div irq", 32'h0000_0001, {31'h0000_0000, irq});
	endtask
	task t_stop;
		int hits;
		hits = 0;
		wr(3'h2, 16'h0001);
		wr(3'h1, 16'h0003);
		wc(8'h80);
		repeat (5) @(negedge clock);
		wc(8'h00);
		repeat (40) begin
			@(negedge clock);
			if (irq !== 1'b0) hits++;
		end
		cmp("stop irq", 32'h0000_0000, hits);
		cmp("stop control", 32'h0000_0000, {24'h00_0000, ctrl});
	endtask
	initial begin
		#20000;
		err_count++;
		final_report;
	end
	initial begin
		{acc_low_we, acc_high_we, operand_we, ctrl_we} = 4'h0;
		wr_data = 16'h0000;
		ctrl_wr_data = 8'h00;
		reset_n = 1'b0;
		err_count = 0;
		tests_run = 0;
		repeat (5) @(negedge clock);
		reset_n = 1'b1;
		repeat (3) @(negedge clock);
		t_reset;
		t_div(32'h1234_5678, 16'h1234);
		t_mul(16'h00da, 16'h0093);
		t_div(32'hffff_ffff, 16'h0001);
		t_mul(16'hffff, 16'hffff);
		t_stop;
		t_mul(16'h0000, 16'h8001);
		final_report;
	end
endmodule
